// [ceu_map.svh]
/*
 * Register offsets, field positions, reset values, cause codes and vector
 * constants of the exception entry unit. Definitions only; included by the
 * unit.
 */
// What this block does
// - interrupt record: 14-bit code, upper bits zero
// - entry saves pc, status word, gp15
// - entry sets block, privilege, bank flags
// - only reset clears fpu-off flag
// - entry writes cause code to record
// - return restores pc and status word
// - return leaves general register fifteen alone
// - reset events branch to fixed address
// - others branch to vector base plus offset, breaks to debug base when enabled
// - itlb multi-hit: reset class, code 140
// - dtlb multi-hit: reset class, code 140
// - break before: code 1E0, base or debug
// - itlb miss: code 040, offset 400
// - itlb protection: code 0A0, offset 100
// - illegal instructions: codes 180, 1A0
// - fpu disabled: codes 800, 820
// - data address error: 0E0 read, 100 write
// - dtlb miss: 040 read, 060 write
// - dtlb protection: 0A0 read, 0C0 write
// - initial page write: code 080, offset 100
// - break after: code 1E0, order 10
// - exceptions to exception record, interrupts elsewhere
// - pick by level, then order, lowest wins
// - manual reset 020, power-on reset 000
`ifndef CEU_MAP_SVH
`define CEU_MAP_SVH

// register byte offsets on the wishbone port
`define CEU_OFS_EXC_REC 8'h00
`define CEU_OFS_INT_REC 8'h04
`define CEU_OFS_VBASE 8'h08
`define CEU_OFS_DBASE 8'h0C
`define CEU_OFS_SPC 8'h10
`define CEU_OFS_SSTAT 8'h14
`define CEU_OFS_SGP15 8'h18
`define CEU_OFS_STATUS 8'h1C
`define CEU_OFS_CTRL 8'h20

// field widths and status word bit positions
`define CEU_INT_CODE_W 14
`define CEU_EXC_CODE_W 12
`define CEU_SR_BL 28
`define CEU_SR_MD 30
`define CEU_SR_RB 29
`define CEU_SR_FD 15
`define CEU_CTRL_DBG_BIT 0

// reset values and vectors
`define CEU_RESET_VECTOR 32'hA0000000
`define CEU_STATUS_RST 32'h700000F0
`define CEU_OFF_100 32'h00000100
`define CEU_OFF_400 32'h00000400
`define CEU_OFF_600 32'h00000600

// cause codes
`define CEU_C_POR 12'h000
`define CEU_C_MAN 12'h020
`define CEU_C_TLBMH 12'h140
`define CEU_C_UBRK 12'h1E0
`define CEU_C_IADE 12'h0E0
`define CEU_C_TLBMR 12'h040
`define CEU_C_TLBMW 12'h060
`define CEU_C_PROTR 12'h0A0
`define CEU_C_PROTW 12'h0C0
`define CEU_C_ILL 12'h180
`define CEU_C_SILL 12'h1A0
`define CEU_C_FPUD 12'h800
`define CEU_C_SFPUD 12'h820
`define CEU_C_TRAP 12'h160
`define CEU_C_DADEW 12'h100
`define CEU_C_FPUX 12'h120
`define CEU_C_IPW 12'h080
`define CEU_C_NMI 14'h01C0

`endif

// [ceu_pkg.sv]
/*
 * Types of the exception entry unit: event source vector, entry result,
 * and the unit's whole state. Constants live in ceu_map.svh.
 */
package ceu_pkg;

    // one bit per source the pipeline and mmu can raise
    typedef struct packed {
        logic itlb_multi;
        logic dtlb_multi;
        logic brk_before;
        logic iaddr_err;
        logic itlb_miss;
        logic itlb_prot;
        logic illegal;
        logic slot_illegal;
        logic fpu_off;
        logic slot_fpu_off;
        logic trap;
        logic daddr_err;
        logic dtlb_miss;
        logic dtlb_prot;
        logic fpu_exc;
        logic page_write;
        logic brk_after;
        logic data_write;
    } ceu_src_t;

    // chosen event: destination and bookkeeping
    typedef struct packed {
        logic hit;
        logic is_reset;
        logic use_dbg;
        logic [11:0] code;
        logic [31:0] offset;
    } ceu_sel_t;

    typedef struct packed {
        logic [11:0] exc_rec;
        logic [13:0] int_rec;
        logic [31:0] vbase;
        logic [31:0] dbase;
        logic [31:0] saved_pc;
        logic [31:0] sstat;
        logic [31:0] sgp15;
        logic [31:0] status;
        logic dbg_en;
        logic redirect;
        logic [31:0] target;
        logic [31:0] rdata;
        logic ack;
    } ceu_state_t;

endpackage

// [ceu_entry.sv]
/*
 * Exception entry unit: picks the winning event, saves pc, status word and
 * gp15, sets the status flags, records the cause and redirects the fetch.
 * Assumes one core clock, a synchronous reset and a classic wishbone
 * master for the control registers; the pipeline presents a stable pc.
 */
`timescale 1ns/1ps
`include "ceu_map.svh"

module ceu_entry (
    input wire logic clk_i,                 // core clock, 50 MHz
    input wire logic rst_i,                 // sync reset, active high
    input wire logic manual_rst_i,          // one-cycle manual reset request
    input wire ceu_pkg::ceu_src_t src_i,    // exception sources, levels
    input wire logic nmi_i,                 // nonmaskable interrupt request
    input wire logic irq_i,                 // general interrupt request
    input wire logic [13:0] irq_code_i,     // code of the general interrupt
    input wire logic ret_i,                 // return_from_handler executes
    input wire logic [31:0] pc_i,           // current program counter
    input wire logic [31:0] gp15_i,         // general register fifteen
    input wire logic wb_cyc_i,              // wishbone cycle
    input wire logic wb_stb_i,              // wishbone strobe
    input wire logic wb_we_i,               // wishbone write
    input wire logic [7:0] wb_adr_i,        // wishbone byte address
    input wire logic [3:0] wb_sel_i,        // wishbone byte enables
    input wire logic [31:0] wb_dat_i,       // wishbone write data
    output logic [31:0] wb_dat_o,           // wishbone read data
    output logic wb_ack_o,                  // wishbone acknowledge
    output logic redirect_o,                // one-cycle fetch redirect
    output logic [31:0] target_o,           // new fetch address
    output logic [31:0] status_o,           // status word
    output logic [31:0] saved_gp15_o        // saved general register fifteen
);

    ceu_pkg::ceu_state_t r;
    ceu_pkg::ceu_state_t next_r;
    ceu_pkg::ceu_sel_t sel;

    // byte-lane merge for 32-bit registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    // build a selection result
    function automatic ceu_pkg::ceu_sel_t pick(input logic rs, input logic dbg,
                                               input logic [11:0] c, input logic [31:0] o);
        ceu_pkg::ceu_sel_t s;
        s.hit = 1'b1;
        s.is_reset = rs;
        s.use_dbg = dbg;
        s.code = c;
        s.offset = o;
        return s;
    endfunction

    // priority: level 1 resets, then level 2 by order; first match wins
    // level then order
    always_comb begin
        sel = '0;
        if (src_i.itlb_multi) begin
            sel = pick(1'b1, 1'b0, `CEU_C_TLBMH, 32'h0);
        end else if (src_i.dtlb_multi) begin
            sel = pick(1'b1, 1'b0, `CEU_C_TLBMH, 32'h0);
        end else if (src_i.brk_before) begin
            sel = pick(1'b0, r.dbg_en, `CEU_C_UBRK, `CEU_OFF_100);
        end else if (src_i.iaddr_err) begin
            sel = pick(1'b0, 1'b0, `CEU_C_IADE, `CEU_OFF_100);
        end else if (src_i.itlb_miss) begin
            sel = pick(1'b0, 1'b0, `CEU_C_TLBMR, `CEU_OFF_400);
        end else if (src_i.itlb_prot) begin
            sel = pick(1'b0, 1'b0, `CEU_C_PROTR, `CEU_OFF_100);
        end else if (src_i.illegal) begin
            sel = pick(1'b0, 1'b0, `CEU_C_ILL, `CEU_OFF_100);
        end else if (src_i.slot_illegal) begin
            sel = pick(1'b0, 1'b0, `CEU_C_SILL, `CEU_OFF_100);
        end else if (src_i.fpu_off) begin
            sel = pick(1'b0, 1'b0, `CEU_C_FPUD, `CEU_OFF_100);
        end else if (src_i.slot_fpu_off) begin
            sel = pick(1'b0, 1'b0, `CEU_C_SFPUD, `CEU_OFF_100);
        end else if (src_i.trap) begin
            sel = pick(1'b0, 1'b0, `CEU_C_TRAP, `CEU_OFF_100);
        end else if (src_i.daddr_err) begin
            sel = pick(1'b0, 1'b0, src_i.data_write ? `CEU_C_DADEW : `CEU_C_IADE,
                       `CEU_OFF_100);
        end else if (src_i.dtlb_miss) begin
            sel = pick(1'b0, 1'b0, src_i.data_write ? `CEU_C_TLBMW : `CEU_C_TLBMR,
                       `CEU_OFF_400);
        end else if (src_i.dtlb_prot) begin
            sel = pick(1'b0, 1'b0, src_i.data_write ? `CEU_C_PROTW : `CEU_C_PROTR,
                       `CEU_OFF_100);
        end else if (src_i.fpu_exc) begin
            sel = pick(1'b0, 1'b0, `CEU_C_FPUX, `CEU_OFF_100);
        end else if (src_i.page_write) begin
            sel = pick(1'b0, 1'b0, `CEU_C_IPW, `CEU_OFF_100);
        end else if (src_i.brk_after) begin
            sel = pick(1'b0, r.dbg_en, `CEU_C_UBRK, `CEU_OFF_100);
        end
    end

    logic bus_req;
    logic bus_wr;
    logic block;
    logic exc_go;
    logic int_go;
    logic nested;
    assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
    assign bus_wr = bus_req & wb_we_i;
    assign block = r.status[`CEU_SR_BL];
    // exception while blocked, with no break source raised, escalates to a manual-reset style entry
    assign nested = sel.hit & block & ~src_i.brk_before & ~src_i.brk_after;
    assign exc_go = sel.hit & (~block | nested);
    // interrupts wait while blocked; nmi outranks the general request
    assign int_go = ~sel.hit & ~block & (nmi_i | irq_i);

    // next state: entry beats return beats software write
    always_comb begin
        logic rst_like;
        logic [31:0] st;
        logic [31:0] wtmp;
        rst_like = 1'b0;
        st = '0;
        wtmp = '0;
        next_r = r;
        next_r.redirect = 1'b0;
        next_r.ack = bus_req;
        next_r.rdata = '0;
        // register reads; unmapped reads return zero
        if (bus_req & ~wb_we_i) begin
            case (wb_adr_i)
                `CEU_OFS_EXC_REC: next_r.rdata = {20'h0, r.exc_rec};
                `CEU_OFS_INT_REC: next_r.rdata = {18'h0, r.int_rec};
                `CEU_OFS_VBASE: next_r.rdata = r.vbase;
                `CEU_OFS_DBASE: next_r.rdata = r.dbase;
                `CEU_OFS_SPC: next_r.rdata = r.saved_pc;
                `CEU_OFS_SSTAT: next_r.rdata = r.sstat;
                `CEU_OFS_SGP15: next_r.rdata = r.sgp15;
                `CEU_OFS_STATUS: next_r.rdata = r.status;
                `CEU_OFS_CTRL: next_r.rdata = {31'h0, r.dbg_en};
                default: next_r.rdata = '0;
            endcase
        end
        // software writes; unmapped writes are acked and dropped
        if (bus_wr) begin
            case (wb_adr_i)
                `CEU_OFS_EXC_REC: begin
                    wtmp = merge({20'h0, r.exc_rec}, wb_dat_i, wb_sel_i);
                    next_r.exc_rec = wtmp[11:0];
                end
                `CEU_OFS_INT_REC: begin
                    wtmp = merge({18'h0, r.int_rec}, wb_dat_i, wb_sel_i);
                    next_r.int_rec = wtmp[13:0];
                end
                `CEU_OFS_VBASE: next_r.vbase = merge(r.vbase, wb_dat_i, wb_sel_i);
                `CEU_OFS_DBASE: next_r.dbase = merge(r.dbase, wb_dat_i, wb_sel_i);
                `CEU_OFS_SPC: next_r.saved_pc = merge(r.saved_pc, wb_dat_i, wb_sel_i);
                `CEU_OFS_SSTAT: next_r.sstat = merge(r.sstat, wb_dat_i, wb_sel_i);
                `CEU_OFS_SGP15: next_r.sgp15 = merge(r.sgp15, wb_dat_i, wb_sel_i);
                `CEU_OFS_STATUS: next_r.status = merge(r.status, wb_dat_i, wb_sel_i);
                `CEU_OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        next_r.dbg_en = wb_dat_i[`CEU_CTRL_DBG_BIT];
                    end
                end
                default: ;
            endcase
        end
        if (ret_i) begin
            next_r.status = r.sstat;
            next_r.redirect = 1'b1;
            next_r.target = r.saved_pc;
        end
        // hardware entry wins over a same-cycle software write
        if (manual_rst_i | exc_go | int_go) begin
            rst_like = manual_rst_i | nested | (exc_go & sel.is_reset);
            next_r.saved_pc = pc_i;
            next_r.sstat = r.status;
            next_r.sgp15 = gp15_i;
            st = r.status;
            st[`CEU_SR_BL] = 1'b1;
            st[`CEU_SR_MD] = 1'b1;
            st[`CEU_SR_RB] = 1'b1;
            if (rst_like) begin
                st[`CEU_SR_FD] = 1'b0;
            end
            next_r.status = st;
            next_r.redirect = 1'b1;
            if (manual_rst_i | nested) begin
                next_r.exc_rec = `CEU_C_MAN;
            end else if (exc_go) begin
                next_r.exc_rec = sel.code;
            end else if (nmi_i) begin
                next_r.int_rec = `CEU_C_NMI;
            end else begin
                next_r.int_rec = irq_code_i;
            end
            if (rst_like) begin
                next_r.target = `CEU_RESET_VECTOR;
                next_r.vbase = '0;
            end else if (exc_go & sel.use_dbg) begin
                next_r.target = r.dbase;
            end else if (exc_go) begin
                next_r.target = r.vbase + sel.offset;
            end else begin
                next_r.target = r.vbase + `CEU_OFF_600;
            end
        end
    end

    // single state register; power-on entry on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.exc_rec <= `CEU_C_POR;
            r.status <= `CEU_STATUS_RST;
            r.redirect <= 1'b1;
            r.target <= `CEU_RESET_VECTOR;
        end else begin
            r <= next_r;
        end
    end

    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign redirect_o = r.redirect;
    assign target_o = r.target;
    assign status_o = r.status;
    assign saved_gp15_o = r.sgp15;

endmodule

// [ceu_entry_assertions.sv]
/* port checker of the exception entry unit.
   assumes one core clock and a sync active-high reset. */
`timescale 1ns/1ps
module ceu_entry_assertions (
    input wire logic clk_i,                 // core clock
    input wire logic rst_i,                 // sync reset, active high
    input wire logic manual_rst_i,          // manual reset request
    input wire logic nmi_i,                 // nonmaskable interrupt
    input wire logic irq_i,                 // general interrupt
    input wire logic ret_i,                 // return_from_handler
    input wire ceu_pkg::ceu_src_t src_i,    // exception sources
    input wire logic [31:0] gp15_i,         // general register fifteen
    input wire logic [31:0] target_o,       // fetch address
    input wire logic [31:0] status_o,       // status word
    input wire logic [31:0] saved_gp15_o,   // saved gp15
    input wire logic wb_cyc_i,              // wishbone cycle
    input wire logic wb_stb_i,              // wishbone strobe
    input wire logic wb_ack_o,              // wishbone acknowledge
    input wire logic redirect_o             // fetch redirect
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // unblocked tlb miss with no reset-class source beside it
    sequence s_plain;
        src_i.itlb_miss && !src_i.itlb_multi && !src_i.dtlb_multi && !manual_rst_i
            && !status_o[28];
    endsequence
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ret;
        ret_i && src_i == '0 && !manual_rst_i && !nmi_i && !irq_i;
    endsequence
    a_ack_answer: assert property (s_taken |=> wb_ack_o) else $error("ack late");
    a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_reset_vector: assert property (
        src_i.itlb_multi || src_i.dtlb_multi || manual_rst_i |=>
        redirect_o && target_o == 32'hA0000000) else $error("reset vector");
    a_reset_fd_clear: assert property (
        manual_rst_i |=> !status_o[15]) else $error("fpu flag kept");
    a_entry_flags: assert property (
        s_plain |=> redirect_o && status_o[30:28] == 3'h7) else $error("flags");
    a_entry_gp15: assert property (
        s_plain |=> saved_gp15_o == $past(gp15_i)) else $error("gp15 not saved");
    a_entry_fd_kept: assert property (
        s_plain |=> status_o[15] == $past(status_o[15])) else $error("fpu flag");
    a_return_redirect: assert property (
        s_ret |=> redirect_o) else $error("no return");
endmodule

bind ceu_entry ceu_entry_assertions u_ceu_entry_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .manual_rst_i(manual_rst_i), .nmi_i(nmi_i), .irq_i(irq_i), .ret_i(ret_i), .src_i(src_i),
    .gp15_i(gp15_i), .target_o(target_o), .status_o(status_o), .saved_gp15_o(saved_gp15_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .redirect_o(redirect_o));

// [ceu_pipe_model.sv]
/* pipeline and mmu model that raises exception sources.
   assumes the unit accepts a source on the edge it is presented. */
`timescale 1ns/1ps
module ceu_pipe_model (
    input wire logic clk_i, // core clock
    input wire logic redirect_i, // fetch redirect from the unit
    output ceu_pkg::ceu_src_t src_o, // exception sources
    output logic [3:0] ctl_o, // manual reset, nmi, irq, return
    output logic [13:0] code_o, // general interrupt code
    output logic [31:0] pc_o, // running program counter
    output logic [31:0] gp15_o // general register fifteen
);
    logic [31:0] last_pc, last_gp15;
    logic seen;
    initial begin
        src_o = '0;
        ctl_o = 4'h0;
        code_o = 14'h0000;
        pc_o = 32'h0C000000;
        gp15_o = 32'h12340000;
    end
    // pc and gp15 move every cycle so a stale capture shows
    always @(posedge clk_i) begin
        pc_o <= pc_o + 32'h00000002;
        gp15_o <= gp15_o + 32'h00010003;
    end
    // one-cycle request, dropped on acceptance to avoid re-entry
    task automatic fire(input ceu_pkg::ceu_src_t s, input logic [3:0] c, input logic [13:0] k);
        @(posedge clk_i);
        src_o <= s;
        ctl_o <= c;
        code_o <= k;
        @(posedge clk_i);
        last_pc = pc_o;
        last_gp15 = gp15_o;
        src_o <= '0;
        ctl_o <= 4'h0;
        code_o <= ~k;
        @(posedge clk_i);
        seen = redirect_i;
    endtask
endmodule

// [test_ceu_entry.sv]
/* self-checking bench of the exception entry unit.
   assumes ceu_pipe_model drives the pipeline side. */
`timescale 1ns/1ps
module test_ceu_entry;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, redirect_o;
    logic [3:0] ctl, wb_sel_i;
    logic [7:0] wb_adr_i;
    logic [13:0] irq_code_i;
    logic [31:0] wb_dat_i, wb_dat_o, target_o, status_o, saved_gp15_o, pc_i, gp15_i, rd, vb;
    ceu_pkg::ceu_src_t src_i, s;
    int n_mismatch, total_checks, i;
    logic [11:0] code [15:1];
    logic [11:0] wcode [6:4];
    ceu_entry u_ceu_entry (.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(ctl[3]), .src_i(src_i),
        .nmi_i(ctl[2]), .irq_i(ctl[1]), .irq_code_i(irq_code_i), .ret_i(ctl[0]), .pc_i(pc_i),
        .gp15_i(gp15_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .redirect_o(redirect_o), .target_o(target_o),
        .status_o(status_o), .saved_gp15_o(saved_gp15_o));
    ceu_pipe_model u_ceu_pipe_model (.clk_i(clk_i), .redirect_i(redirect_o), .src_o(src_i),
        .ctl_o(ctl), .code_o(irq_code_i), .pc_o(pc_i), .gp15_o(gp15_i));
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
        rd = wb_dat_o;
        if (k == 20) chk(32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic entry(input ceu_pkg::ceu_src_t sv, input logic [3:0] c,
        input logic [31:0] tgt, input logic [7:0] ra, input logic [31:0] rv);
        u_ceu_pipe_model.fire(sv, c, 14'h2ABC);
        chk({31'h0, u_ceu_pipe_model.seen}, 32'h1);
        chk(target_o, tgt);
        wb(1'b0, ra, 32'h0);
        chk(rd, rv);
    endtask
    task automatic back();
        logic [31:0] p;
        logic [31:0] g;
        p = u_ceu_pipe_model.last_pc;
        g = u_ceu_pipe_model.last_gp15;
        chk(saved_gp15_o, g);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, p);
        u_ceu_pipe_model.fire('0, 4'h1, 14'h0000);
        chk(target_o, p);
        chk(status_o, 32'h40008000);
        chk(saved_gp15_o, g);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // hang guard, far beyond the few hundred cycles used
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 8'h8F;
        {wb_adr_i, wb_dat_i} = 40'h0;
        code = '{12'h1E0, 12'h0E0, 12'h040, 12'h0A0, 12'h180, 12'h1A0, 12'h800, 12'h820,
            12'h160, 12'h0E0, 12'h040, 12'h0A0, 12'h120, 12'h080, 12'h1E0};
        wcode = '{12'h100, 12'h060, 12'h0C0};
        vb = 32'h8C000000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h04, 32'hFFFFFFFF);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00003FFF);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 3; i++) begin
            wb(1'b1, 8'h1C, 32'h40008000);
            s = 18'h20000 >> i;
            if (i == 2) entry('0, 4'h8, 32'hA0000000, 8'h00, 32'h020);
            else entry(s, 4'h0, 32'hA0000000, 8'h00, 32'h140);
            chk(status_o & 32'h8000, 32'h0);
        end
        wb(1'b1, 8'h08, vb);
        wb(1'b1, 8'h1C, 32'h40008000);
        for (i = 1; i < 19; i++) begin
            s = '0;
            s[i > 15 ? i - 12 : i] = 1'b1;
            s[0] = (i > 15);
            entry(s, 4'h0, vb + ((i == 13 || i == 5 || i == 17) ? 32'h400 : 32'h100), 8'h00,
                {20'h0, i > 15 ? wcode[i - 12] : code[i]});
            chk(status_o, 32'h70008000);
            back();
        end
        s = '0;
        s.itlb_prot = 1'b1;
        s.illegal = 1'b1;
        entry(s, 4'h0, vb + 32'h100, 8'h00, 32'h0A0);
        back();
        wb(1'b1, 8'h0C, 32'h88001000);
        wb(1'b1, 8'h20, 32'h1);
        entry(18'h08000, 4'h0, 32'h88001000, 8'h00, 32'h1E0);
        back();
        entry(18'h00002, 4'h0, 32'h88001000, 8'h00, 32'h1E0);
        back();
        entry('0, 4'h2, vb + 32'h600, 8'h04, 32'h2ABC);
        back();
        entry('0, 4'h4, vb + 32'h600, 8'h00, 32'h1E0);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h01C0);
        entry(18'h00080, 4'h0, 32'hA0000000, 8'h00, 32'h020);
        test_done();
    end
endmodule
